// >>> verilog/wdog_can_consts.svh
// constants for the watchdog, hardware and transceiver control words
// assumes the register bank is clocked at 50 MHz and reset by a global rst
`ifndef WDOG_CAN_CONSTS_SVH
`define WDOG_CAN_CONSTS_SVH

// ==========================================================
// register offsets
`define HWC_ADDR        7'h02
`define WDC_ADDR        7'h03
`define CANC_ADDR       7'h04

// ==========================================================
// writable masks, reset values, fail-safe pattern and retention masks
`define HWC_WMASK       16'h1e64
`define HWC_SOFT_KEEP   16'h0200
`define HWC_RST_KEEP    16'h1240
`define WDC_WMASK       16'h8077
`define WDC_RESET       16'h0014
`define WDC_RST_KEEP    16'h0010
`define CANC_WMASK      16'h0007
`define CANC_RESET      16'h0020
`define CANC_DEV_RESET  16'h0021
`define CANC_FAIL_PAT   16'h0009
`define CANC_FAIL_KEEP  16'h00e0

// ==========================================================
// field positions
`define HWC_STOP_B1     2
`define HWC_FAIL_ON     5
`define HWC_SOFT_NORST  6
`define WDC_STOP_B0     6
`define WDC_TYPE        5
`define WDC_BUS_WAKE    4
`define WDC_CHECKSUM    15

// ==========================================================
// transceiver mode lower-bit codes
`define CAN_LO_WAKE     2'b01
`define CAN_LO_RECV     2'b10
`define CAN_LO_NORM     2'b11

// ==========================================================
// watchdog periods in ms, indexed by period code
`define WD_P0_MS        14'd10
`define WD_P1_MS        14'd20
`define WD_P2_MS        14'd50
`define WD_P3_MS        14'd100
`define WD_P4_MS        14'd200
`define WD_P5_MS        14'd500
`define WD_P6_MS        14'd1000
`define WD_P7_MS        14'd10000

`endif

// >>> verilog/wdog_can_pkg.sv
// types shared by the control-word register bank
// assumes nothing beyond the constants header
package wdog_can_pkg;
  typedef logic [6:0]  regaddr_t;
  typedef logic [15:0] word_t;
  typedef logic [2:0]  period_code_t;
  typedef logic [13:0] period_ms_t;
endpackage

// >>> verilog/wdog_period_lut.sv
// watchdog period decoder: period code to period in ms
// assumes code comes from a register on the same clock
`timescale 1ns/1ns
`include "wdog_can_consts.svh"
module wdog_period_lut (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  // code in, period out
  input  wire wdog_can_pkg::period_code_t wdogPeriodCode,
  output wdog_can_pkg::period_ms_t        periodMs
);
  import wdog_can_pkg::*;

  // ==========================================================
  // registered lookup so the timing engine sees a clean value
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      periodMs <= `WD_P4_MS;
    end else begin
      case (wdogPeriodCode)
        3'h0: periodMs <= `WD_P0_MS;
        3'h1: periodMs <= `WD_P1_MS;
        3'h2: periodMs <= `WD_P2_MS;
        3'h3: periodMs <= `WD_P3_MS;
        3'h4: periodMs <= `WD_P4_MS;
        3'h5: periodMs <= `WD_P5_MS;
        3'h6: periodMs <= `WD_P6_MS;
        default: periodMs <= `WD_P7_MS;
      endcase
    end
  end
endmodule

// >>> verilog/watchdog_can_control_regs.sv
// hardware, watchdog and transceiver control words with their device-side effects
// assumes the serial interface decodes frames into single-cycle write and read
// strobes on clk, and that mode-change events come from the device state machine
// as single-cycle pulses on the same clock
`timescale 1ns/1ns
`include "wdog_can_consts.svh"
module watchdog_can_control_regs (
  // clock and reset (rst is the power-on reset)
  input  wire logic                       clk,
  input  wire logic                       rst,
  // register access from the serial interface
  input  wire logic                       wrEn,
  input  wire wdog_can_pkg::regaddr_t     wrAddr,
  input  wire wdog_can_pkg::word_t        wrData,
  input  wire logic                       rdEn,
  input  wire wdog_can_pkg::regaddr_t     rdAddr,
  output wdog_can_pkg::word_t             rdData,
  output logic                            rdValid,
  // device mode events, one-cycle pulses, and the transceiver code loaded on restart
  input  wire logic                       softResetPulse,
  input  wire logic                       restartEntry,
  input  wire logic                       stopToNormal,
  input  wire logic                       sleepEntry,
  input  wire logic                       stopEntry,
  input  wire logic                       failSafeEntry,
  input  wire logic [1:0]                 restartCanCause,
  // device status levels
  input  wire logic                       system_error_flag,
  input  wire logic                       failureFlag,
  input  wire logic                       wakePinIsFailOut,
  input  wire logic                       swDevMode,
  // device-side updates of watchdog fields
  input  wire logic                       wdogHwUpdate,
  input  wire logic                       wdogHwStopB0,
  input  wire logic                       wdogHwBusWake,
  input  wire wdog_can_pkg::period_code_t wdogHwPeriod,
  // decoded controls toward the rest of the device
  output logic                            fail_output,
  output logic [1:0]                      stopWdogDisable,
  output logic                            wdogWindowMode,
  output logic                            wdog_start_on_bus_wake,
  output logic                            wdogChecksumBit,
  output wdog_can_pkg::period_code_t      wdog_period_code,
  output wdog_can_pkg::period_ms_t        wdogPeriodMs,
  output logic [2:0]                      canTransceiverMode,
  output logic                            softResetNoPin,
  output wdog_can_pkg::word_t             canCtrlWord
);
  import wdog_can_pkg::*;

  // ==========================================================
  // storage
  word_t hwCtrl_q;
  word_t hwCtrl_d;
  word_t wdCtrl_q;
  word_t wdCtrl_d;
  word_t canCtrl_q;
  word_t canCtrl_d;
  logic  initLoad_q;
  logic  failOut_q;

  // ==========================================================
  // helpers
  // merge a software write: only writable bits change, all other bits keep their stored value
  function automatic word_t mergeWrite(input word_t oldVal, input word_t newVal,
                                       input word_t wMask);
    mergeWrite = (oldVal & ~wMask) | (newVal & wMask);
  endfunction

  // reset value for the transceiver word, depending on development mode
  function automatic word_t canResetValue(input logic devMode);
    canResetValue = devMode ? `CANC_DEV_RESET : `CANC_RESET;
  endfunction

  logic wrHw;
  logic wrWd;
  logic wrCan;

  // address decode for writes; unmapped writes fall through silently
  assign wrHw  = wrEn && (wrAddr == `HWC_ADDR);
  assign wrWd  = wrEn && (wrAddr == `WDC_ADDR);
  assign wrCan = wrEn && (wrAddr == `CANC_ADDR);

  // ==========================================================
  // hardware control word
  // priority: soft reset, restart, device clears, then software write;
  // a device clear beats a software write in the same cycle
  always_comb begin
    hwCtrl_d = hwCtrl_q;
    if (softResetPulse) begin
      hwCtrl_d = hwCtrl_q & `HWC_SOFT_KEEP;
    end else if (restartEntry) begin
      // bit 5 is outside the keep mask, so software activation is dropped
      hwCtrl_d = hwCtrl_q & `HWC_RST_KEEP;
    end else begin
      if (wrHw) begin
        hwCtrl_d = mergeWrite(hwCtrl_q, wrData, `HWC_WMASK);
      end
      if (stopToNormal) begin
        hwCtrl_d[`HWC_STOP_B1] = 1'b0;
      end
    end
  end

  // power-on value is all zeros
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hwCtrl_q <= 16'h0000;
    end else begin
      hwCtrl_q <= hwCtrl_d;
    end
  end

  // ==========================================================
  // watchdog control word
  // device updates of stop disable, bus wake and period win over a write
  always_comb begin
    wdCtrl_d = wdCtrl_q;
    if (softResetPulse) begin
      wdCtrl_d = `WDC_RESET;
    end else if (restartEntry) begin
      // bit 4 is set in the reset value, so it must be masked out before the
      // retained bit is merged back, or a cleared bit would come back as one
      wdCtrl_d = (`WDC_RESET & ~`WDC_RST_KEEP) | (wdCtrl_q & `WDC_RST_KEEP);
    end else begin
      if (wrWd) begin
        // parity bit is stored as written and only mirrored out
        wdCtrl_d = mergeWrite(wdCtrl_q, wrData, `WDC_WMASK);
      end
      if (wdogHwUpdate) begin
        wdCtrl_d[`WDC_STOP_B0]  = wdogHwStopB0;
        wdCtrl_d[`WDC_BUS_WAKE] = wdogHwBusWake;
        wdCtrl_d[2:0]           = wdogHwPeriod;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wdCtrl_q <= `WDC_RESET;
    end else begin
      wdCtrl_q <= wdCtrl_d;
    end
  end

  // ==========================================================
  // transceiver control word
  // fail-safe force ranks below power-on load, soft reset and restart, and above
  // a software write and low-power entry in the same cycle
  always_comb begin
    canCtrl_d = canCtrl_q;
    if (initLoad_q) begin
      // development mode is a level from the device state logic, taken after release
      canCtrl_d = canResetValue(swDevMode);
    end else if (softResetPulse) begin
      canCtrl_d = canResetValue(swDevMode);
    end else if (restartEntry) begin
      canCtrl_d = {14'h0000, restartCanCause};
    end else if (failSafeEntry) begin
      canCtrl_d = (canCtrl_q & `CANC_FAIL_KEEP) | `CANC_FAIL_PAT;
    end else begin
      if (wrCan) begin
        canCtrl_d = mergeWrite(canCtrl_q, wrData, `CANC_WMASK);
      end
      // device touches only the lower two bits on low-power entry
      if (sleepEntry) begin
        if ((canCtrl_q[1:0] == `CAN_LO_NORM) && !system_error_flag) begin
          canCtrl_d[1:0] = `CAN_LO_WAKE;
        end else if (canCtrl_q[1:0] == `CAN_LO_RECV) begin
          canCtrl_d[1:0] = `CAN_LO_WAKE;
        end
        // wake capable and off codes fall through untouched
      end
      // stop entry keeps receive only as chosen beforehand by the host
      if (stopEntry) begin
        canCtrl_d[1:0] = canCtrl_q[1:0];
      end
    end
  end

  // the constant here is overwritten one cycle after release if needed
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      canCtrl_q <= `CANC_RESET;
    end else begin
      canCtrl_q <= canCtrl_d;
    end
  end

  // one-shot flag marking the first clock after power-on release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      initLoad_q <= 1'b1;
    end else begin
      initLoad_q <= 1'b0;
    end
  end

  // ==========================================================
  // fail output
  // a failure keeps the output on regardless of the software bit, so
  // clearing the software bit alone cannot release it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      failOut_q <= 1'b0;
    end else begin
      failOut_q <= failureFlag
                   || (hwCtrl_d[`HWC_FAIL_ON] && wakePinIsFailOut);
    end
  end

  assign fail_output = failOut_q;

  // ==========================================================
  // register read path
  // reserved bits can be set in the transceiver word storage and are masked on the way out
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdData <= 16'h0000;
    end else if (rdEn) begin
      case (rdAddr)
        `HWC_ADDR:  rdData <= hwCtrl_q & `HWC_WMASK;
        `WDC_ADDR:  rdData <= wdCtrl_q & `WDC_WMASK;
        `CANC_ADDR: rdData <= canCtrl_q & `CANC_WMASK;
        default:    rdData <= 16'h0000;
      endcase
    end
  end

  // read answer strobe one cycle after the request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdValid <= 1'b0;
    end else begin
      rdValid <= rdEn;
    end
  end

  // ==========================================================
  // decoded controls, straight from the stored words
  assign stopWdogDisable        = {hwCtrl_q[`HWC_STOP_B1], wdCtrl_q[`WDC_STOP_B0]};
  assign wdogWindowMode         = wdCtrl_q[`WDC_TYPE];
  assign wdog_start_on_bus_wake = wdCtrl_q[`WDC_BUS_WAKE];
  assign wdogChecksumBit        = wdCtrl_q[`WDC_CHECKSUM];
  assign wdog_period_code       = wdCtrl_q[2:0];
  assign canTransceiverMode     = canCtrl_q[2:0];
  assign softResetNoPin         = hwCtrl_q[`HWC_SOFT_NORST];
  assign canCtrlWord            = canCtrl_q;

  // ==========================================================
  // period lookup for the watchdog timing engine
  wdog_period_lut u_period (
    .clk            (clk),
    .rst            (rst),
    .wdogPeriodCode (wdCtrl_q[2:0]),
    .periodMs       (wdogPeriodMs)
  );

endmodule

// >>> tb/wcc_monitor.sv
// checker for the control-word bank, bound to its top module
// assumes one-cycle event pulses and a read answered one cycle after its strobe
`timescale 1ns/1ns
module wcc_monitor (
  // clock and reset
  input wire logic                clk,
  input wire logic                rst,
  // register access and events
  input wire logic                wrEn,
  input wire logic                rdEn,
  input wire logic                rdValid,
  input wire wdog_can_pkg::word_t rdData,
  input wire logic                softResetPulse,
  input wire logic                restartEntry,
  input wire logic                stopToNormal,
  input wire logic                sleepEntry,
  input wire logic                stopEntry,
  input wire logic                failSafeEntry,
  // levels and decoded outputs
  input wire logic                system_error_flag,
  input wire logic                failureFlag,
  input wire logic                wakePinIsFailOut,
  input wire logic                fail_output,
  input wire logic [1:0]          stopWdogDisable,
  input wire logic [2:0]          canTransceiverMode,
  input wire wdog_can_pkg::word_t canCtrlWord
);
  import wdog_can_pkg::*;
  logic live_q;
  logic calm;
  // the first edge after reset is the power-on load of the bus word, so it is kept out
  always_ff @(posedge clk or posedge rst) begin
    if (rst) live_q <= 1'b0;
    else live_q <= 1'b1;
  end
  // no event or write that may legally overrule a low-power rewrite
  assign calm = live_q & ~(softResetPulse | restartEntry | failSafeEntry | wrEn);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_rs;
    restartEntry && !failureFlag;
  endsequence
  sequence s_fs;
    failSafeEntry && live_q && !softResetPulse && !restartEntry;
  endsequence
  // =====================================================
  // assertions
  a_read_answer: assert property (rdEn |=> rdValid)
    else $error("read strobe not answered");
  a_read_single: assert property (!rdEn |=> !rdValid)
    else $error("read valid without strobe");
  a_reserved_zero: assert property (rdValid |-> !rdData[3] && rdData[14:13] == 2'h0
    && rdData[8:7] == 2'h0) else $error("reserved bit read as one");
  a_fail_hold: assert property (failureFlag |=> fail_output)
    else $error("fail output off during failure");
  a_fail_gate: assert property (!failureFlag && !wakePinIsFailOut |=> !fail_output)
    else $error("fail output on without cause");
  a_restart_release: assert property (s_rs |=> !fail_output)
    else $error("fail output kept after restart");
  a_stop_clear: assert property (stopToNormal |=> !stopWdogDisable[1])
    else $error("stop disable bit 1 not cleared");
  a_sleep_normal: assert property (calm && sleepEntry && !system_error_flag
    && canTransceiverMode[1:0] == 2'h3 |=> canTransceiverMode[1:0] == 2'h1)
    else $error("normal mode not rewritten on sleep");
  a_sleep_recv: assert property (calm && sleepEntry && canTransceiverMode[1:0] == 2'h2
    |=> canTransceiverMode[1:0] == 2'h1) else $error("receive mode not rewritten on sleep");
  a_stop_keep: assert property (calm && stopEntry && !sleepEntry
    |=> $stable(canTransceiverMode)) else $error("bus mode changed on stop");
  a_top_bit: assert property (calm |=> $stable(canTransceiverMode[2]))
    else $error("device changed bus mode bit 2");
  a_failsafe_word: assert property (s_fs |=>
    canCtrlWord == {8'h00, $past(canCtrlWord[7:5]), 5'h09}) else $error("fail-safe word");
endmodule

bind watchdog_can_control_regs wcc_monitor u_wcc_monitor (
  .clk, .rst, .wrEn, .rdEn, .rdValid, .rdData, .softResetPulse, .restartEntry,
  .stopToNormal, .sleepEntry, .stopEntry, .failSafeEntry, .system_error_flag,
  .failureFlag, .wakePinIsFailOut, .fail_output, .stopWdogDisable,
  .canTransceiverMode, .canCtrlWord);

// >>> tb/host_model.sv
// host side of the register access: single-word write and read
// assumes a strobe is taken at the edge after it is raised
`timescale 1ns/1ns
module host_model (
  // clock
  input wire logic                    clk,
  // register access toward the bank
  output logic                        wrEn,
  output wdog_can_pkg::regaddr_t      wrAddr,
  output wdog_can_pkg::word_t         wrData,
  output logic                        rdEn,
  output wdog_can_pkg::regaddr_t      rdAddr,
  input wire wdog_can_pkg::word_t     rdData,
  input wire logic                    rdValid
);
  import wdog_can_pkg::*;
  // idle at time zero
  initial begin
    wrEn = 1'b0;
    rdEn = 1'b0;
    wrAddr = 7'h00;
    rdAddr = 7'h00;
    wrData = 16'h0000;
  end
  // released lines carry the inverse, so a stale value never looks valid
  task automatic wr(input regaddr_t a, input word_t d);
    @(posedge clk);
    wrEn <= 1'b1;
    wrAddr <= a;
    wrData <= d;
    @(posedge clk);
    wrEn <= 1'b0;
    wrAddr <= ~a;
    wrData <= ~d;
  endtask
  // a missing valid returns unknowns, which no comparison accepts
  task automatic rd(input regaddr_t a, output word_t d);
    @(posedge clk);
    rdEn <= 1'b1;
    rdAddr <= a;
    @(posedge clk);
    rdEn <= 1'b0;
    rdAddr <= ~a;
    @(negedge clk);
    d = (rdValid === 1'b1) ? rdData : 16'hxxxx;
  endtask
endmodule

// >>> tb/tb_top.sv
// testbench for the control-word bank: register sequences with expected words
// assumes the host model for access and one-cycle event pulses from here
`timescale 1ns/1ns
module tb_top;
  import wdog_can_pkg::*;
  localparam logic [13:0] PMS [8] = '{14'h000a, 14'h0014, 14'h0032, 14'h0064,
                                      14'h00c8, 14'h01f4, 14'h03e8, 14'h2710};
  // {mode written, sleep not stop, system error, mode expected}
  localparam logic [7:0] MODES [9] = '{8'h71, 8'hf5, 8'h7b, 8'h51, 8'h42,
                                      8'h63, 8'h31, 8'h00, 8'h94};
  logic clk = 1'b0, rst = 1'b1;
  logic [5:0] ev = 6'h00;
  logic [1:0] restartCanCause = 2'h0;
  logic system_error_flag = 1'b0, failureFlag = 1'b0, wakePinIsFailOut = 1'b0;
  logic swDevMode = 1'b0, wdogHwUpdate = 1'b0, wdogHwStopB0 = 1'b0, wdogHwBusWake = 1'b0;
  period_code_t wdogHwPeriod = 3'h0, wdog_period_code;
  logic wrEn, rdEn, rdValid, fail_output, wdogWindowMode, wdog_start_on_bus_wake;
  logic wdogChecksumBit, softResetNoPin;
  logic [1:0] stopWdogDisable;
  logic [2:0] canTransceiverMode;
  regaddr_t wrAddr, rdAddr;
  word_t wrData, rdData, canCtrlWord;
  period_ms_t wdogPeriodMs;
  int err_count = 0, total_checks = 0;

  always #10 clk = ~clk;

  host_model u_host (.clk, .wrEn, .wrAddr, .wrData, .rdEn, .rdAddr, .rdData, .rdValid);
  watchdog_can_control_regs u_watchdog_can_control_regs (
    .clk, .rst, .wrEn, .wrAddr, .wrData, .rdEn, .rdAddr, .rdData, .rdValid,
    .softResetPulse(ev[0]), .restartEntry(ev[1]), .stopToNormal(ev[2]),
    .sleepEntry(ev[3]), .stopEntry(ev[4]), .failSafeEntry(ev[5]), .restartCanCause,
    .system_error_flag, .failureFlag, .wakePinIsFailOut, .swDevMode, .wdogHwUpdate,
    .wdogHwStopB0, .wdogHwBusWake, .wdogHwPeriod, .fail_output, .stopWdogDisable,
    .wdogWindowMode, .wdog_start_on_bus_wake, .wdogChecksumBit, .wdog_period_code,
    .wdogPeriodMs, .canTransceiverMode, .softResetNoPin, .canCtrlWord);

  // =====================================================
  // tasks
  task automatic chk(input string n, input word_t e, input word_t g);
    total_checks++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask
  // the registered period lookup lags a write by one cycle, so two falling edges pass
  task automatic w(input regaddr_t a, input word_t d);
    u_host.wr(a, d);
    repeat (2) @(negedge clk);
  endtask
  task automatic r(input regaddr_t a, input word_t e);
    word_t d;
    u_host.rd(a, d);
    chk("rdData", e, d);
  endtask
  task automatic pulse(input logic [5:0] e);
    @(posedge clk);
    ev <= e;
    @(posedge clk);
    ev <= 6'h00;
    repeat (2) @(negedge clk);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    close_out();
  end

  // =====================================================
  // main sequence
  initial begin
    logic [2:0] pc;
    word_t d;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(negedge clk);
    r(7'h02, 16'h0000);
    r(7'h03, 16'h0014);
    r(7'h04, 16'h0000);
    chk("canWord", 16'h0020, canCtrlWord);
    chk("periodMs", 16'h00c8, 16'(wdogPeriodMs));
    w(7'h10, 16'hffff);
    r(7'h10, 16'h0000);
    $display("test 1 done");
    // every period code, reserved bits written as ones
    for (int i = 0; i < 8; i++) begin
      pc = 3'(i);
      d = {1'b1, 8'h00, pc[0], 3'h6, pc};
      w(7'h03, d | 16'h7f88);
      r(7'h03, d);
      chk("periodMs", 16'(PMS[i]), 16'(wdogPeriodMs));
      chk("code", 16'(pc), 16'(wdog_period_code));
      chk("stopB0", 16'(pc[0]), 16'(stopWdogDisable[0]));
      chk("window", 16'h0001, 16'(wdogWindowMode));
      chk("busWake", 16'h0001, 16'(wdog_start_on_bus_wake));
      chk("checksum", 16'h0001, 16'(wdogChecksumBit));
    end
    w(7'h03, 16'h0000);
    chk("window", 16'h0000, 16'(wdogWindowMode));
    chk("busWake", 16'h0000, 16'(wdog_start_on_bus_wake));
    chk("checksum", 16'h0000, 16'(wdogChecksumBit));
    @(posedge clk) {wdogHwUpdate, wdogHwStopB0, wdogHwPeriod} <= 5'h1e;
    @(posedge clk) wdogHwUpdate <= 1'b0;
    repeat (2) @(negedge clk);
    r(7'h03, 16'h0046);
    $display("test 2 done");
    // restart keeps selected bits and drops software fail activation
    @(posedge clk) wakePinIsFailOut <= 1'b1;
    w(7'h02, 16'hffff);
    r(7'h02, 16'h1e64);
    chk("failOut", 16'h0001, 16'(fail_output));
    chk("noPin", 16'h0001, 16'(softResetNoPin));
    @(posedge clk) restartCanCause <= 2'h2;
    pulse(6'h02);
    chk("failOut", 16'h0000, 16'(fail_output));
    r(7'h02, 16'h1240);
    r(7'h03, 16'h0004);
    chk("canWord", 16'h0002, canCtrlWord);
    $display("test 3 done");
    // failure holds the output; pin setting gates software activation
    @(posedge clk) failureFlag <= 1'b1;
    w(7'h02, 16'h0020);
    w(7'h02, 16'h0000);
    chk("failOut", 16'h0001, 16'(fail_output));
    @(posedge clk) failureFlag <= 1'b0;
    repeat (2) @(negedge clk);
    chk("failOut", 16'h0000, 16'(fail_output));
    @(posedge clk) wakePinIsFailOut <= 1'b0;
    w(7'h02, 16'h0024);
    chk("failOut", 16'h0000, 16'(fail_output));
    chk("stopB1", 16'h0001, 16'(stopWdogDisable[1]));
    pulse(6'h04);
    chk("stopB1", 16'h0000, 16'(stopWdogDisable[1]));
    $display("test 4 done");
    // bus modes against sleep and stop entry
    foreach (MODES[k]) begin
      @(posedge clk) system_error_flag <= MODES[k][3];
      w(7'h04, {13'h1fff, MODES[k][7:5]});
      pulse(MODES[k][4] ? 6'h08 : 6'h10);
      chk("canWord", {13'h0000, MODES[k][2:0]}, canCtrlWord);
      chk("canMode", {13'h0000, MODES[k][2:0]}, 16'(canTransceiverMode));
      r(7'h04, {13'h0000, MODES[k][2:0]});
    end
    $display("test 5 done");
    // soft reset in development mode, then fail-safe entry
    @(posedge clk) swDevMode <= 1'b1;
    w(7'h02, 16'hffff);
    pulse(6'h01);
    r(7'h02, 16'h0200);
    r(7'h03, 16'h0014);
    chk("canWord", 16'h0021, canCtrlWord);
    @(posedge clk) swDevMode <= 1'b0;
    pulse(6'h01);
    chk("canWord", 16'h0020, canCtrlWord);
    w(7'h04, 16'h0007);
    pulse(6'h20);
    chk("canWord", 16'h0029, canCtrlWord);
    r(7'h04, 16'h0001);
    $display("test 6 done");
    close_out();
  end
endmodule
